// ---- design/branch_skip_control_unit.sv ----
// Control-flow, compare, skip and I/O bit operations of an 8-bit core
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Indirect call loads Z, three cycles
// - Equal registers skip next instruction, flags kept
// - Compares set Z N V C H, one cycle
// - Register bit clear skips, 1/2/3 cycles
// - Register bit set skips, 1/2/3 cycles
// - I/O bit clear skips, 1/2/3 cycles
// - I/O bit set skips, 1/2/3 cycles
// - Flag-set branch to PC+k+1, 1/2 cycles
// - Flag-clear branch to PC+k+1, 1/2 cycles
// - Same-or-higher on C=0, lower on C=1
// - Signed greater-or-equal when N xor V zero
// - Signed less-than when N xor V one
// - Only compares, interrupt return and idle flag loads change the status flags
// - Set I/O bit, two cycles
// - Clear I/O bit, two cycles
// - Indirect jump loads Z, two cycles
module branch_skip_control_unit
    import branch_skip_pkg::*;
#(
    parameter int PC_W = 10  // Program counter width in words
) (
    // Clock and reset
    input  wire logic            i_ref_clk,
    input  wire logic            i_srst,
    // Operation request
    input  wire logic            i_req_valid,
    input  wire req_s            i_req,
    input  wire logic [15:0]     i_z_ptr,
    input  wire logic [PC_W-1:0] i_stack_top,
    // Loads from the rest of the core, taken only when idle
    input  wire logic            i_pc_we,
    input  wire logic [PC_W-1:0] i_pc_wdata,
    input  wire logic            i_flags_we,
    input  wire logic [7:0]      i_flags_wdata,
    // Status
    output var  logic            o_busy,
    output var  logic            o_done,
    output var  logic [PC_W-1:0] o_pc,
    output var  logic [7:0]      o_flags,
    // I/O register write
    output var  logic            o_io_we,
    output var  io_wr_s          o_io_wr,
    // Stack
    output var  logic            o_stack_push,
    output var  logic            o_stack_pop,
    output var  logic [PC_W-1:0] o_push_pc
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic            accept;        // Request taken this cycle
    logic            last;          // Final cycle of the running operation
    logic [2:0]      cnt_r;         // Cycles left
    logic [2:0]      cyc_nxt;       // Length of the accepted operation
    logic [PC_W-1:0] pc_nxt;        // Target of the accepted operation
    logic [PC_W-1:0] pend_pc_r;
    logic [7:0]      flags_nxt;     // Flags after the accepted operation
    logic [7:0]      pend_flags_r;
    io_wr_s          io_nxt;        // I/O write of the accepted operation
    io_wr_s          pend_io_r;
    logic            io_we_nxt;
    logic            pend_io_we_r;
    logic            push_nxt;
    logic            pend_push_r;
    logic            pop_nxt;
    logic            pend_pop_r;
    logic [PC_W-1:0] pc_inc;        // Address of the next word
    logic [PC_W-1:0] br_tgt;        // PC + k + 1
    logic [PC_W-1:0] z_tgt;         // Z cut to the program counter width
    logic [8:0]      diff;          // Compare difference with borrow
    logic [7:0]      res;
    logic            cin;
    logic            test_bit;      // Bit under test for skips
    logic            skip;          // Skip condition met
    logic            taken;         // Branch condition met

    assign accept = i_req_valid && !o_busy;
    assign last   = (cnt_r == 3'h1);
    assign pc_inc = o_pc + PC_W'(1);
    assign br_tgt = pc_inc + {{(PC_W-7){i_req.offset[6]}}, i_req.offset};
    assign z_tgt  = i_z_ptr[PC_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Compare arithmetic; the difference is never stored
    always_comb begin
        cin  = (i_req.op == COMPARE_WITH_CARRY_OP) ? o_flags[FLAG_C] : 1'b0;
        diff = {1'b0, i_req.rd_val} - {1'b0, i_req.rr_val} - {8'h00, cin};
        res  = diff[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode: target, length and side effects of the requested operation
    always_comb begin
        cyc_nxt   = CYC_ONE;
        pc_nxt    = pc_inc;
        flags_nxt = o_flags;  // Left alone unless a compare or interrupt return runs
        io_nxt    = '{addr: i_req.io_addr, data: i_req.io_val};
        io_we_nxt = 1'b0;
        push_nxt  = 1'b0;
        pop_nxt   = 1'b0;
        taken     = 1'b0;
        skip      = 1'b0;
        test_bit  = i_req.rd_val[i_req.bit_sel];
        case (i_req.op)
            INDIRECT_JUMP_OP: begin
                cyc_nxt = CYC_TWO;
                pc_nxt  = z_tgt;
            end
            INDIRECT_CALL_OP: begin
                cyc_nxt  = CYC_CALL;
                pc_nxt   = z_tgt;
                push_nxt = 1'b1;
            end
            SUBROUTINE_RETURN_OP, INTERRUPT_RETURN_OP: begin
                cyc_nxt = CYC_RETURN;
                pc_nxt  = i_stack_top;
                pop_nxt = 1'b1;
                if (i_req.op == INTERRUPT_RETURN_OP) begin
                    flags_nxt[FLAG_I] = 1'b1;
                end
            end
            COMPARE_SKIP_EQUAL_OP: begin
                skip = (i_req.rd_val == i_req.rr_val);
            end
            REGISTER_COMPARE_OP, COMPARE_WITH_CARRY_OP, COMPARE_IMMEDIATE_OP: begin
                // Carry-chained compare only keeps Z if it was already set
                flags_nxt[FLAG_Z] = (res == 8'h00) &&
                                    ((i_req.op != COMPARE_WITH_CARRY_OP) || o_flags[FLAG_Z]);
                flags_nxt[FLAG_N] = res[7];
                flags_nxt[FLAG_V] = (i_req.rd_val[7] & ~i_req.rr_val[7] & ~res[7]) |
                                    (~i_req.rd_val[7] & i_req.rr_val[7] & res[7]);
                flags_nxt[FLAG_S] = res[7] ^ flags_nxt[FLAG_V];
                flags_nxt[FLAG_C] = diff[8];
                flags_nxt[FLAG_H] = (~i_req.rd_val[3] & i_req.rr_val[3]) |
                                    (i_req.rr_val[3] & res[3]) | (res[3] & ~i_req.rd_val[3]);
            end
            SKIP_REG_BIT_CLEAR_OP: skip = !test_bit;
            SKIP_REG_BIT_SET_OP:   skip = test_bit;
            SKIP_IO_BIT_CLEAR_OP: begin
                test_bit = i_req.io_val[i_req.bit_sel];
                skip     = !test_bit;
            end
            SKIP_IO_BIT_SET_OP: begin
                test_bit = i_req.io_val[i_req.bit_sel];
                skip     = test_bit;
            end
            // C and Z positions give the same-or-higher/lower and equal aliases
            BRANCH_FLAG_SET_OP:   taken = o_flags[i_req.bit_sel];
            BRANCH_FLAG_CLEAR_OP: taken = !o_flags[i_req.bit_sel];
            BRANCH_SIGNED_GE_OP:  taken = !(o_flags[FLAG_N] ^ o_flags[FLAG_V]);
            BRANCH_SIGNED_LT_OP:  taken = o_flags[FLAG_N] ^ o_flags[FLAG_V];
            SET_IO_BIT_OP, CLEAR_IO_BIT_OP: begin
                cyc_nxt   = CYC_TWO;
                io_we_nxt = 1'b1;
                io_nxt.data[i_req.bit_sel] = (i_req.op == SET_IO_BIT_OP);
            end
            default: ;  // No-operation steps one word
        endcase
        // Skip length follows the size of the skipped instruction
        if (skip) begin
            cyc_nxt = i_req.two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;
            pc_nxt  = o_pc + (i_req.two_word ? PC_W'(3) : PC_W'(2));
        end
        if (taken) begin
            cyc_nxt = CYC_TWO;
            pc_nxt  = br_tgt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counter; busy covers every cycle of the operation
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cnt_r  <= 3'h0;
            o_busy <= 1'b0;
        end else if (accept) begin
            cnt_r  <= cyc_nxt;
            o_busy <= 1'b1;
        end else if (o_busy) begin
            cnt_r  <= cnt_r - 3'h1;
            o_busy <= !last;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending results, captured once so operands may change while busy
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            pend_pc_r    <= '0;
            pend_flags_r <= FLAGS_RST;
            pend_io_r    <= '0;
            pend_io_we_r <= 1'b0;
            pend_push_r  <= 1'b0;
            pend_pop_r   <= 1'b0;
        end else if (accept) begin
            pend_pc_r    <= pc_nxt;
            pend_flags_r <= flags_nxt;
            pend_io_r    <= io_nxt;
            pend_io_we_r <= io_we_nxt;
            pend_push_r  <= push_nxt;
            pend_pop_r   <= pop_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Commit on the last cycle; side loads only while idle so they never
    // race an operation's own update of the PC or flags
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_pc    <= '0;
            o_flags <= FLAGS_RST;
        end else if (o_busy && last) begin
            o_pc    <= pend_pc_r;
            o_flags <= pend_flags_r;
        end else if (!o_busy && !i_req_valid) begin
            if (i_pc_we) begin
                o_pc <= i_pc_wdata;
            end
            if (i_flags_we) begin
                o_flags <= i_flags_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-cycle strobes at commit
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_done       <= 1'b0;
            o_io_we      <= 1'b0;
            o_io_wr      <= '0;
            o_stack_push <= 1'b0;
            o_stack_pop  <= 1'b0;
            o_push_pc    <= '0;
        end else begin
            o_done       <= o_busy && last;
            o_io_we      <= o_busy && last && pend_io_we_r;
            o_stack_push <= o_busy && last && pend_push_r;
            o_stack_pop  <= o_busy && last && pend_pop_r;
            if (o_busy && last) begin
                o_io_wr   <= pend_io_r;
                o_push_pc <= o_pc + PC_W'(1);  // Return address after the call
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    sequence s_busy3; o_busy [*3]; endsequence
    sequence s_busy2; o_busy [*2]; endsequence

    property p_indirect_call_op;
        accept && i_req.op == INDIRECT_CALL_OP |=> s_busy3 ##1
            (o_done && o_stack_push && o_pc == $past(z_tgt, 4));
    endproperty
    a_indirect_call_op: assert property (p_indirect_call_op) else $error("indirect call wrong");

    property p_indirect_jump_op;
        accept && i_req.op == INDIRECT_JUMP_OP |=> s_busy2 ##1
            (!o_busy && o_pc == $past(z_tgt, 3));
    endproperty
    a_indirect_jump_op: assert property (p_indirect_jump_op) else $error("indirect jump wrong");

    property p_interrupt_return_op;
        accept && i_req.op == INTERRUPT_RETURN_OP |=> o_busy [*4] ##1
            (o_stack_pop && o_flags[FLAG_I] && o_pc == $past(i_stack_top, 5));
    endproperty
    a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("interrupt return wrong");

    property p_cmp_equal;
        accept && i_req.op == REGISTER_COMPARE_OP && i_req.rd_val == i_req.rr_val
            |-> ##2 (o_flags[FLAG_Z] && !o_flags[FLAG_C] && !o_flags[FLAG_N]);
    endproperty
    a_cmp_equal: assert property (p_cmp_equal) else $error("compare flags wrong");

    property p_skip_two;
        accept && skip && i_req.two_word |=> s_busy3 ##1
            (o_pc == $past(o_pc, 4) + PC_W'(3));
    endproperty
    a_skip_two: assert property (p_skip_two) else $error("two-word skip wrong");

    property p_no_skip;
        accept && i_req.op == SKIP_REG_BIT_SET_OP && !i_req.rd_val[i_req.bit_sel]
            |=> o_busy ##1 (o_done && o_pc == $past(o_pc, 2) + PC_W'(1));
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("untaken skip wrong");

    property p_branch_taken;
        accept && i_req.op == BRANCH_FLAG_SET_OP && o_flags[i_req.bit_sel]
            |=> s_busy2 ##1 (o_pc == $past(br_tgt, 3));
    endproperty
    a_branch_taken: assert property (p_branch_taken) else $error("taken branch wrong");

    property p_signed_lt;
        accept && i_req.op == BRANCH_SIGNED_LT_OP && (o_flags[FLAG_N] == o_flags[FLAG_V])
            |=> o_busy ##1 (!o_busy && o_pc == $past(pc_inc, 2));
    endproperty
    a_signed_lt: assert property (p_signed_lt) else $error("signed branch wrong");

    // Flags at accept of any op but a compare or interrupt return; judged at done, so every length fits
    logic [7:0] kept_flags_r;
    logic       kept_r;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            kept_flags_r <= FLAGS_RST;
            kept_r       <= 1'b0;
        end else if (accept) begin
            kept_flags_r <= o_flags;
            kept_r       <= !(i_req.op inside {REGISTER_COMPARE_OP, COMPARE_WITH_CARRY_OP,
                                               COMPARE_IMMEDIATE_OP, INTERRUPT_RETURN_OP});
        end
    end

    property p_flags_kept;
        o_done && kept_r |-> o_flags == kept_flags_r;
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

    property p_clear_io;
        accept && i_req.op == CLEAR_IO_BIT_OP |=> s_busy2 ##1 (o_io_we && o_io_wr.addr == $past(i_req.io_addr, 3) &&
            o_io_wr.data == ($past(i_req.io_val, 3) & ~(8'h01 << $past(i_req.bit_sel, 3))));
    endproperty
    a_clear_io: assert property (p_clear_io) else $error("clear bit wrong");

endmodule : branch_skip_control_unit

`default_nettype wire

// ---- design/branch_skip_pkg.sv ----
// Package: opcodes, flag positions, cycle counts and carriers for the branch/skip unit
package branch_skip_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Status flag bit positions
    localparam int FLAG_C = 0;  // Carry; also same-or-higher / lower branches
    localparam int FLAG_Z = 1;  // Zero; branch_equal_op / branch_not_equal_op
    localparam int FLAG_N = 2;  // Negative; branch_minus_op / branch_plus_op
    localparam int FLAG_V = 3;  // Overflow
    localparam int FLAG_S = 4;  // Sign, N xor V
    localparam int FLAG_H = 5;  // Half carry
    localparam int FLAG_T = 6;  // Transfer bit
    localparam int FLAG_I = 7;  // Global interrupt enable

    // Status flag register after reset
    localparam logic [7:0] FLAGS_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts per operation
    localparam logic [2:0] CYC_ONE      = 3'h1;  // Compare, untaken branch, no skip
    localparam logic [2:0] CYC_TWO      = 3'h2;  // Taken branch, jump, I/O bit write
    localparam logic [2:0] CYC_CALL     = 3'h3;  // Indirect call
    localparam logic [2:0] CYC_RETURN   = 3'h4;  // Both returns
    localparam logic [2:0] CYC_SKIP_ONE = 3'h2;  // Skip over a one-word instruction
    localparam logic [2:0] CYC_SKIP_TWO = 3'h3;  // Skip over a two-word instruction

    ////////////////////////////////////////////////////////////////////////////
    // Operations; flag branch aliases are set/clear with a flag position
    typedef enum logic [4:0] {
        NOP_OP                 = 5'h00,
        INDIRECT_JUMP_OP       = 5'h01,
        INDIRECT_CALL_OP       = 5'h02,
        SUBROUTINE_RETURN_OP   = 5'h03,
        INTERRUPT_RETURN_OP    = 5'h04,
        COMPARE_SKIP_EQUAL_OP  = 5'h05,
        REGISTER_COMPARE_OP    = 5'h06,
        COMPARE_WITH_CARRY_OP  = 5'h07,
        COMPARE_IMMEDIATE_OP   = 5'h08,
        SKIP_REG_BIT_CLEAR_OP  = 5'h09,
        SKIP_REG_BIT_SET_OP    = 5'h0A,
        SKIP_IO_BIT_CLEAR_OP   = 5'h0B,
        SKIP_IO_BIT_SET_OP     = 5'h0C,
        BRANCH_FLAG_SET_OP     = 5'h0D,
        BRANCH_FLAG_CLEAR_OP   = 5'h0E,
        BRANCH_SIGNED_GE_OP    = 5'h0F,
        BRANCH_SIGNED_LT_OP    = 5'h10,
        SET_IO_BIT_OP          = 5'h11,
        CLEAR_IO_BIT_OP        = 5'h12
    } op_e;

    // One decoded operation with its operands
    typedef struct packed {
        op_e        op;        // Operation
        logic [7:0] rd_val;    // First general register value
        logic [7:0] rr_val;    // Second register value or immediate
        logic [2:0] bit_sel;   // Bit number or flag position
        logic [6:0] offset;    // Signed branch offset in words
        logic [4:0] io_addr;   // I/O register address
        logic [7:0] io_val;    // Current value of that I/O register
        logic       two_word;  // Instruction after this one is two words
    } req_s;

    // One I/O register write
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } io_wr_s;

endpackage : branch_skip_pkg

// ---- verif/tb_branch_skip_control_unit.sv ----
// Self-checking testbench for the branch, skip, compare and I/O bit unit
`timescale 1ns/1ps
`default_nettype none
module tb_branch_skip_control_unit
    import branch_skip_pkg::*;
();
    ////////////////////////////////////////////////////////////////////////////
    // Settings and signals
    localparam int  PCW = 10;    // Program counter width under test
    localparam time DLY = 1ns;   // Drive delay after each rising edge
    logic            clk;        // 200 MHz clock
    logic            srst;       // Synchronous reset
    logic            req_valid;  // Request strobe
    req_s            req;        // Request operands
    logic [15:0]     z_ptr;      // Pointer for jump and call
    logic [PCW-1:0]  stack_top;  // Value a return pops
    logic            pc_we;      // Idle program counter load
    logic [PCW-1:0]  pc_wdata;   // Loaded program counter
    logic            flags_we;   // Idle flag load
    logic [7:0]      flags_wdata; // Loaded flags
    logic            o_busy;
    logic            o_done;
    logic [PCW-1:0]  o_pc;
    logic [7:0]      o_flags;
    logic            o_io_we;
    io_wr_s          o_io_wr;
    logic            o_stack_push;
    logic            o_stack_pop;
    logic [PCW-1:0]  o_push_pc;
    logic [2:0]      cap_str;    // Strobes {io_we, push, pop} seen with done
    io_wr_s          cap_io;     // I/O write seen with done
    logic [PCW-1:0]  cap_push_pc; // Return address seen with done
    int              miscompares;
    int              comparisons;

    branch_skip_control_unit #(.PC_W(PCW)) branch_skip_control_unit_inst (
        .i_ref_clk(clk), .i_srst(srst), .i_req_valid(req_valid), .i_req(req), .i_z_ptr(z_ptr),
        .i_stack_top(stack_top), .i_pc_we(pc_we), .i_pc_wdata(pc_wdata), .i_flags_we(flags_we),
        .i_flags_wdata(flags_wdata), .o_busy(o_busy), .o_done(o_done), .o_pc(o_pc), .o_flags(o_flags),
        .o_io_we(o_io_we), .o_io_wr(o_io_wr), .o_stack_push(o_stack_push), .o_stack_pop(o_stack_pop),
        .o_push_pc(o_push_pc)
    );

    // Free-running clock, half period 2.5 ns
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    function automatic req_s mk(input op_e op, input logic [7:0] rd, input logic [7:0] rr, input logic [2:0] b,
                                input logic [6:0] off, input logic [4:0] ioa, input logic [7:0] iov,
                                input logic tw);
        return '{op, rd, rr, b, off, ioa, iov, tw};
    endfunction : mk

    // Expected flags after a compare; the difference itself is never stored
    function automatic logic [7:0] cmp_flags(input logic [7:0] old, input logic [7:0] a, input logic [7:0] b,
                                             input logic use_c);
        logic [7:0] r;
        logic [7:0] f;
        r = a - b - {7'h00, use_c & old[FLAG_C]};
        f = old;
        f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        f[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        f[FLAG_N] = r[7];
        f[FLAG_S] = r[7] ^ f[FLAG_V];
        f[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        f[FLAG_Z] = (r == 8'h00) & (~use_c | old[FLAG_Z]);
        return f;
    endfunction : cmp_flags

    // Idle load of PC and flags; only taken while nothing is requested
    task automatic set_state(input logic [PCW-1:0] pc, input logic [7:0] f);
        pc_wdata = pc;
        flags_wdata = f;
        pc_we = 1'b1;
        flags_we = 1'b1;
        @(posedge clk);
        #DLY;
        pc_we = 1'b0;
        flags_we = 1'b0;
    endtask : set_state

    // One operation: request, count busy cycles, catch the done cycle, judge PC, flags, strobes
    task automatic run(input req_s r, input logic [PCW-1:0] epc, input logic [7:0] ef, input int en,
                       input logic [2:0] es);
        int   n;
        int   k;
        logic seen;
        n = 0;
        seen = 1'b0;
        req = r;
        req_valid = 1'b1;
        @(posedge clk);
        #DLY;
        req_valid = 1'b0;
        // Busy rises at the accepting edge, so the first busy cycle is seen here
        if (o_busy === 1'b1) n++;
        for (k = 0; k < 12 && !seen; k++) begin
            @(posedge clk);
            #DLY;
            if (o_busy === 1'b1) n++;
            if (o_done === 1'b1) begin
                seen = 1'b1;
                cap_str = {o_io_we, o_stack_push, o_stack_pop};
                cap_io = o_io_wr;
                cap_push_pc = o_push_pc;
            end
        end
        chk("done", {15'h0000, seen}, 16'h0001);
        chk("cycles", n[15:0], en[15:0]);
        chk("pc", {6'h00, o_pc}, {6'h00, epc});
        chk("flags", {8'h00, o_flags}, {8'h00, ef});
        chk("strobes", {13'h0000, cap_str}, {13'h0000, es});
    endtask : run

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_flow();
        z_ptr = 16'hF123;
        stack_top = 10'h2AB;
        set_state(10'h005, 8'h5A);
        run(mk(INDIRECT_JUMP_OP, 8'h00, 8'h00, 3'h0, 7'h00, 5'h00, 8'h00, 1'b0), 10'h123, 8'h5A, 2, 3'h0);
        set_state(10'h3FF, 8'hA5);
        run(mk(INDIRECT_CALL_OP, 8'h00, 8'h00, 3'h0, 7'h00, 5'h00, 8'h00, 1'b0), 10'h123, 8'hA5, 3, 3'h2);
        chk("push_pc", {6'h00, cap_push_pc}, 16'h0000);
        run(mk(SUBROUTINE_RETURN_OP, 8'h00, 8'h00, 3'h0, 7'h00, 5'h00, 8'h00, 1'b0), 10'h2AB, 8'hA5, 4, 3'h1);
        set_state(10'h010, 8'h00);
        run(mk(INTERRUPT_RETURN_OP, 8'h00, 8'h00, 3'h0, 7'h00, 5'h00, 8'h00, 1'b0), 10'h2AB, 8'h80, 4, 3'h1);
        $display("test flow done");
    endtask : t_flow

    task automatic t_compare();
        op_e        ops[3] = '{REGISTER_COMPARE_OP, COMPARE_WITH_CARRY_OP, COMPARE_IMMEDIATE_OP};
        logic [7:0] av[5]  = '{8'h00, 8'h01, 8'h80, 8'h10, 8'h7F};
        logic [7:0] bv[5]  = '{8'h00, 8'h02, 8'h01, 8'h08, 8'h80};
        logic [7:0] old;
        for (int o = 0; o < 3; o++) begin
            for (int p = 0; p < 10; p++) begin
                old = (p < 5) ? 8'hC3 : 8'h3C;
                set_state(10'h040, old);
                run(mk(ops[o], av[p % 5], bv[p % 5], 3'h0, 7'h00, 5'h00, 8'h00, 1'b0), 10'h041,
                    cmp_flags(old, av[p % 5], bv[p % 5], ops[o] == COMPARE_WITH_CARRY_OP), 1, 3'h0);
            end
        end
        $display("test compare done");
    endtask : t_compare

    task automatic t_skip();
        op_e        ops[5] = '{COMPARE_SKIP_EQUAL_OP, SKIP_REG_BIT_CLEAR_OP, SKIP_REG_BIT_SET_OP,
                               SKIP_IO_BIT_CLEAR_OP, SKIP_IO_BIT_SET_OP};
        logic [7:0] val;
        logic [2:0] b;
        logic       skip;
        int         adv;
        for (int o = 0; o < 5; o++) begin
            for (int c = 0; c < 4; c++) begin
                b = 3'(o + 2 * c);
                val = (c[0] ? 8'h00 : 8'hFF) ^ (8'h01 << b);
                skip = (o == 0) ? c[0] : ((o % 2 == 1) ? ~val[b] : val[b]);
                adv = skip ? (c[1] ? 3 : 2) : 1;
                set_state(10'h100, 8'h2D);
                // Register ops see the inverse on the I/O operand and I/O ops on the register one
                run(mk(ops[o], (o == 0) ? 8'h5A : ((o < 3) ? val : ~val), c[0] ? 8'h5A : 8'h5B, b, 7'h00, 5'h07,
                       (o < 3) ? ~val : val, c[1]), 10'h100 + 10'(adv), 8'h2D, adv, 3'h0);
                if (o > 0) begin
                    run(mk(ops[o], val, val, b, 7'h00, 5'h07, val, c[1]), 10'h100 + 10'(2 * adv),
                        8'h2D, adv, 3'h0);
                end
            end
        end
        $display("test skip done");
    endtask : t_skip

    task automatic t_branch();
        logic [7:0] f;
        logic [6:0] off;
        logic       tk;
        for (int i = 0; i < 32; i++) begin
            f = i[3] ? (8'h01 << i[2:0]) : ~(8'h01 << i[2:0]);
            off = i[4] ? 7'h7D : 7'h05;
            tk = (i[3] == 1'b1) ? 1'b1 : 1'b0;
            set_state(10'h001, f);
            run(mk(BRANCH_FLAG_SET_OP, 8'h00, 8'h00, i[2:0], off, 5'h00, 8'h00, 1'b0),
                tk ? 10'h002 + {{3{off[6]}}, off} : 10'h002, f, tk ? 2 : 1, 3'h0);
            set_state(10'h001, f);
            run(mk(BRANCH_FLAG_CLEAR_OP, 8'h00, 8'h00, i[2:0], off, 5'h00, 8'h00, 1'b0),
                tk ? 10'h002 : 10'h002 + {{3{off[6]}}, off}, f, tk ? 1 : 2, 3'h0);
        end
        // Sign flag set opposite to N xor V so a branch on S alone is caught
        for (int nv = 0; nv < 4; nv++) begin
            f = {3'h0, ~(nv[1] ^ nv[0]), nv[0], nv[1], 2'h0};
            tk = nv[1] ^ nv[0];
            set_state(10'h200, f);
            run(mk(BRANCH_SIGNED_GE_OP, 8'h00, 8'h00, 3'h0, 7'h7F, 5'h00, 8'h00, 1'b0),
                tk ? 10'h201 : 10'h200, f, tk ? 1 : 2, 3'h0);
            set_state(10'h200, f);
            run(mk(BRANCH_SIGNED_LT_OP, 8'h00, 8'h00, 3'h0, 7'h7F, 5'h00, 8'h00, 1'b0),
                tk ? 10'h200 : 10'h201, f, tk ? 2 : 1, 3'h0);
        end
        $display("test branch done");
    endtask : t_branch

    task automatic t_iobit();
        for (int b = 0; b < 8; b++) begin
            set_state(10'h300, 8'h81);
            run(mk(SET_IO_BIT_OP, 8'h00, 8'h00, 3'(b), 7'h00, 5'(31 - b), 8'h96, 1'b0),
                10'h301, 8'h81, 2, 3'h4);
            chk("set_io", 16'(cap_io), 16'({5'(31 - b), 8'h96 | (8'h01 << b)}));
            run(mk(CLEAR_IO_BIT_OP, 8'h00, 8'h00, 3'(b), 7'h00, 5'(b), 8'h96, 1'b0), 10'h302, 8'h81, 2, 3'h4);
            chk("clear_io", 16'(cap_io), 16'({5'(b), 8'h96 & ~(8'h01 << b)}));
        end
        $display("test iobit done");
    endtask : t_iobit

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        miscompares = 0;
        comparisons = 0;
        srst = 1'b1;
        {req_valid, pc_we, flags_we} = 3'h0;
        req = mk(NOP_OP, 8'h00, 8'h00, 3'h0, 7'h00, 5'h00, 8'h00, 1'b0);
        {z_ptr, stack_top, pc_wdata, flags_wdata} = '0;
        repeat (10) @(posedge clk);
        #DLY;
        srst = 1'b0;
        chk("reset", {o_busy, o_done, o_io_we, o_stack_push, o_stack_pop, o_flags}, 16'h0000);
        chk("reset_pc", {6'h00, o_pc}, 16'h0000);
        t_flow();
        t_compare();
        t_skip();
        t_branch();
        t_iobit();
        end_sim();
    end

    // Run should finish in under a thousand cycles; 20000 cycles means a hang
    initial begin
        #100000;
        miscompares++;
        $display("Watchdog expired");
        end_sim();
    end

endmodule : tb_branch_skip_control_unit
`default_nettype wire
